// ==== core/fpo_sequencer.sv ====
`timescale 1ns/1ps

// Behaviour
// - Clearing the completion flag launches; flag stays clear until the operation fully ends.
// - One-time field is 64 bytes: 8 phrases of four 16-bit words, never erased.
// - Launch index must be 101 for one-time, 000 erase-all/unsecure, 001 block/sector.
// - One-time program accepts phrase index 0x0000 to 0x0007 only, else access error.
// - One-time program checks phrase erased, programs it, then verifies by read-back.
// - One-time program of an already programmed phrase is refused with access error.
// - A phrase programmed to all ones still counts erased and may be programmed again.
// - Program-storage reads return invalid data while one-time programming runs.
// - Command unavailable in current mode sets access error instead of running.
// - Verify sets verify error on any error, uncorrectable flag on non-correctable errors.
// - Code 0x08 erases all storage, verifies, and releases security on a pass.
// - Erase-all and unsecure set protection violation if any region is protected.
// - Code 0x09 erases and verifies the block named by address [17:16].
// - Block and sector erase flag access error on an invalid block select.
// - Block erase needs phrase-aligned program address or word-aligned data address.
// - Block erase flags protection violation when any region of the block is protected.
// - Code 0x0A erases then verifies the program sector holding the given address.
// - Sector erase flags access error if address [2:0] nonzero, violation if protected.
// - Code 0x0B erases all storage and releases security only on success.
// - Failed unsecure verify copies the array's verify error and uncorrectable flags, ends, and leaves security unchanged.
module fpo_sequencer
  import fpo_pkg::*;
#(
  parameter logic [1:0] PF_BLK_SEL = PF_BLK_SEL_DEF,
  parameter logic [1:0] DF_BLK_SEL = DF_BLK_SEL_DEF,
  parameter int PROG_CYCLES = PROG_CYC
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic param_wr,
  input wire logic [2:0] param_slot_index,
  input wire logic [15:0] param_wdata,
  output logic [15:0] param_rdata,
  input wire logic cmd_launch,
  input wire logic [NUM_CMDS-1:0] mode_cmd_en,
  input wire logic pflash_protected_any,
  input wire logic dflash_protected_any,
  input wire logic sector_protected,
  output logic [1:0] prot_query_blk,
  output logic [15:0] prot_query_addr,
  output logic arr_start,
  output logic [1:0] arr_op,
  output logic [1:0] arr_blk,
  output logic [15:0] arr_addr,
  input wire logic arr_done,
  input wire logic arr_verify_err,
  input wire logic arr_verify_uncorr,
  input wire logic info_factory_fill,
  output logic pflash_rd_invalid,
  output logic device_secured,
  output logic cmd_complete_flag,
  output logic access_error_flag,
  output logic protect_violation_flag,
  output logic verify_error_flag,
  output logic verify_uncorrectable_flag
);

  function automatic logic [NUM_CMDS-1:0] cmd_onehot(input logic [7:0] code);
    logic [NUM_CMDS-1:0] oh;
    oh = '0;
    case (code)
      CMD_PROG_ONCE: oh[MODE_BIT_ONCE] = 1'b1;
      CMD_ERASE_ALL: oh[MODE_BIT_ALL] = 1'b1;
      CMD_ERASE_BLK: oh[MODE_BIT_BLK] = 1'b1;
      CMD_ERASE_SECT: oh[MODE_BIT_SECT] = 1'b1;
      CMD_UNSECURE: oh[MODE_BIT_UNSEC] = 1'b1;
      default: oh = '0;
    endcase
    return oh;
  endfunction : cmd_onehot

  function automatic logic phrase_aligned(input logic [15:0] addr);
    return addr[2:0] == 3'h0;
  endfunction : phrase_aligned

  // Number of 16-bit words that differ between two phrases
  function automatic logic [2:0] word_diffs(input logic [PHRASE_W-1:0] a, input logic [PHRASE_W-1:0] b);
    logic [2:0] n;
    n = 3'h0;
    for (int w = 0; w < WORDS_PER_PHRASE; w++) begin
      if (a[w*WORD_W +: WORD_W] != b[w*WORD_W +: WORD_W]) begin
        n = n + 3'h1;
      end
    end
    return n;
  endfunction : word_diffs

  fpo_state_t state_reg;
  fpo_state_t state_next;
  logic [15:0] param_reg [NUM_SLOTS];
  logic [2:0] launch_idx_reg;
  logic [PROG_CNT_W-1:0] prog_cnt_reg;
  logic [PROG_CNT_W-1:0] prog_cnt_next;
  logic complete_reg;
  logic complete_next;
  logic acc_reg;
  logic acc_next;
  logic fpv_reg;
  logic fpv_next;
  logic ver_reg;
  logic ver_next;
  logic unc_reg;
  logic unc_next;
  logic secured_reg;
  logic secured_next;
  logic arr_start_reg;
  logic arr_start_next;
  logic [1:0] arr_op_reg;
  logic [1:0] arr_op_next;
  logic store_wr;

  // Launch is only honoured while the flag is set, so a clear during a busy
  // command cannot restart the sequencer mid-operation.
  wire launch_go = cmd_launch && complete_reg && (state_reg == FPO_IDLE);
  wire param_wr_ok = param_wr && complete_reg && (param_slot_index < 3'(NUM_SLOTS));

  wire [7:0] code = param_reg[SLOT_CMD][CMD_CODE_LSB +: 8];
  wire [1:0] blk_sel = param_reg[SLOT_CMD][BLK_SEL_LSB +: 2];
  wire [15:0] addr_lo = param_reg[SLOT_ADDR];
  wire [2:0] phrase_idx = addr_lo[2:0];
  wire [NUM_CMDS-1:0] code_oh = cmd_onehot(code);
  wire mode_ok = |(code_oh & mode_cmd_en);
  wire blk_is_pf = blk_sel == PF_BLK_SEL;
  wire blk_is_df = blk_sel == DF_BLK_SEL;

  wire [PHRASE_W-1:0] once_words = {param_reg[SLOT_WORD0+3], param_reg[SLOT_WORD0+2],
                                    param_reg[SLOT_WORD0+1], param_reg[SLOT_WORD0]};
  wire [PHRASE_W-1:0] once_rd;
  wire phrase_erased = once_rd == PHRASE_ERASED;
  wire [2:0] diff_cnt = word_diffs(once_rd, once_words);

  // Launch-time access checks per command
  wire acc_once = (launch_idx_reg != IDX_PROG_ONCE) || (addr_lo > ONCE_MAX_IDX);
  wire acc_all = launch_idx_reg != IDX_NO_PARAM;
  wire acc_blk = (launch_idx_reg != IDX_ADDR) || !(blk_is_pf || blk_is_df)
                 || (blk_is_pf && !phrase_aligned(addr_lo)) || (blk_is_df && addr_lo[0]);
  wire acc_sect = (launch_idx_reg != IDX_ADDR) || !blk_is_pf || !phrase_aligned(addr_lo);
  wire fpv_all = pflash_protected_any || dflash_protected_any;
  wire fpv_blk = (blk_is_pf && pflash_protected_any) || (blk_is_df && dflash_protected_any);
  wire erase_all_kind = (code == CMD_ERASE_ALL) || (code == CMD_UNSECURE);
  wire prog_last = prog_cnt_reg == PROG_CNT_W'(PROG_CYCLES - 1);

  fpo_once_store u_once_store (
    .clk_sys(clk_sys),
    .factory_fill(info_factory_fill),
    .rd_idx(phrase_idx),
    .rd_data(once_rd),
    .wr_en(store_wr),
    .wr_idx(phrase_idx),
    .wr_data(once_words)
  );

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        param_reg[i] <= 16'h0000;
      end
    end else if (param_wr_ok) begin
      param_reg[param_slot_index] <= param_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state_reg <= FPO_IDLE;
      launch_idx_reg <= 3'h0;
      prog_cnt_reg <= '0;
      complete_reg <= 1'b1;
      acc_reg <= 1'b0;
      fpv_reg <= 1'b0;
      ver_reg <= 1'b0;
      unc_reg <= 1'b0;
      secured_reg <= SECURE_RST;
      arr_start_reg <= 1'b0;
      arr_op_reg <= FPO_ARR_ERASE_ALL;
    end else begin
      state_reg <= state_next;
      if (launch_go) begin
        launch_idx_reg <= param_slot_index;
      end
      prog_cnt_reg <= prog_cnt_next;
      complete_reg <= complete_next;
      acc_reg <= acc_next;
      fpv_reg <= fpv_next;
      ver_reg <= ver_next;
      unc_reg <= unc_next;
      secured_reg <= secured_next;
      arr_start_reg <= arr_start_next;
      arr_op_reg <= arr_op_next;
    end
  end

  always_comb begin
    state_next = state_reg;
    prog_cnt_next = prog_cnt_reg;
    complete_next = complete_reg;
    acc_next = acc_reg;
    fpv_next = fpv_reg;
    ver_next = ver_reg;
    unc_next = unc_reg;
    secured_next = secured_reg;
    arr_start_next = 1'b0;
    arr_op_next = arr_op_reg;
    store_wr = 1'b0;
    case (state_reg)
      FPO_IDLE: begin
        if (launch_go) begin
          // Status of the previous command is dropped at the new launch
          complete_next = 1'b0;
          acc_next = 1'b0;
          fpv_next = 1'b0;
          ver_next = 1'b0;
          unc_next = 1'b0;
          state_next = FPO_EVAL;
        end
      end
      FPO_EVAL: begin
        state_next = FPO_FIN;
        if (!mode_ok) begin
          acc_next = 1'b1;
        end else begin
          case (code)
            CMD_PROG_ONCE: begin
              if (acc_once) begin
                acc_next = 1'b1;
              end else begin
                state_next = FPO_CHECK;
              end
            end
            CMD_ERASE_ALL, CMD_UNSECURE: begin
              if (acc_all) begin
                acc_next = 1'b1;
              end else if (fpv_all) begin
                fpv_next = 1'b1;
              end else begin
                arr_op_next = FPO_ARR_ERASE_ALL;
                arr_start_next = 1'b1;
                state_next = FPO_ARR_WAIT;
              end
            end
            CMD_ERASE_BLK: begin
              if (acc_blk) begin
                acc_next = 1'b1;
              end else if (fpv_blk) begin
                fpv_next = 1'b1;
              end else begin
                arr_op_next = FPO_ARR_ERASE_BLK;
                arr_start_next = 1'b1;
                state_next = FPO_ARR_WAIT;
              end
            end
            CMD_ERASE_SECT: begin
              if (acc_sect) begin
                acc_next = 1'b1;
              end else if (sector_protected) begin
                fpv_next = 1'b1;
              end else begin
                arr_op_next = FPO_ARR_ERASE_SECT;
                arr_start_next = 1'b1;
                state_next = FPO_ARR_WAIT;
              end
            end
            default: acc_next = 1'b1;
          endcase
        end
      end
      FPO_CHECK: begin
        // The field cannot be erased, so programming a phrase that is no longer all ones is refused
        if (phrase_erased) begin
          prog_cnt_next = '0;
          state_next = FPO_PROG;
        end else begin
          acc_next = 1'b1;
          state_next = FPO_FIN;
        end
      end
      FPO_PROG: begin
        prog_cnt_next = prog_cnt_reg + PROG_CNT_W'(1);
        if (prog_last) begin
          store_wr = 1'b1;
          state_next = FPO_VERIFY;
        end
      end
      FPO_VERIFY: begin
        // One bad word counts as correctable, several as not
        if (diff_cnt != 3'h0) begin
          ver_next = 1'b1;
        end
        if (diff_cnt > 3'h1) begin
          unc_next = 1'b1;
        end
        state_next = FPO_FIN;
      end
      FPO_ARR_WAIT: begin
        if (arr_done) begin
          ver_next = arr_verify_err;
          unc_next = arr_verify_uncorr;
          if (erase_all_kind && !arr_verify_err && !arr_verify_uncorr) begin
            secured_next = 1'b0;
          end
          state_next = FPO_FIN;
        end
      end
      FPO_FIN: begin
        complete_next = 1'b1;
        state_next = FPO_IDLE;
      end
      default: state_next = FPO_IDLE;
    endcase
  end

  assign param_rdata = (param_slot_index < 3'(NUM_SLOTS)) ? param_reg[param_slot_index] : 16'h0000;
  assign prot_query_blk = blk_sel;
  assign prot_query_addr = addr_lo;
  assign arr_start = arr_start_reg;
  assign arr_op = arr_op_reg;
  assign arr_blk = blk_sel;
  assign arr_addr = addr_lo;
  // Reads are blocked for the whole one-time sequence, erased check included
  assign pflash_rd_invalid = (state_reg == FPO_CHECK) || (state_reg == FPO_PROG)
                             || (state_reg == FPO_VERIFY);
  assign device_secured = secured_reg;
  assign cmd_complete_flag = complete_reg;
  assign access_error_flag = acc_reg;
  assign protect_violation_flag = fpv_reg;
  assign verify_error_flag = ver_reg;
  assign verify_uncorrectable_flag = unc_reg;

endmodule : fpo_sequencer

// ==== shared/fpo_pkg.sv ====
package fpo_pkg;

  // Command codes held in the upper byte of parameter slot 0
  localparam logic [7:0] CMD_PROG_ONCE = 8'h07;
  localparam logic [7:0] CMD_ERASE_ALL = 8'h08;
  localparam logic [7:0] CMD_ERASE_BLK = 8'h09;
  localparam logic [7:0] CMD_ERASE_SECT = 8'h0a;
  localparam logic [7:0] CMD_UNSECURE = 8'h0b;

  // Slot index that must stand at launch for each command
  localparam logic [2:0] IDX_PROG_ONCE = 3'h5;
  localparam logic [2:0] IDX_NO_PARAM = 3'h0;
  localparam logic [2:0] IDX_ADDR = 3'h1;

  // Parameter slots
  localparam int NUM_SLOTS = 6;
  localparam int SLOT_CMD = 0;
  localparam int SLOT_ADDR = 1;
  localparam int SLOT_WORD0 = 2;
  localparam int CMD_CODE_LSB = 8;
  localparam int BLK_SEL_LSB = 0;

  // One-time field: 8 phrases of four 16-bit words
  localparam int ONCE_PHRASES = 8;
  localparam int WORDS_PER_PHRASE = 4;
  localparam int WORD_W = 16;
  localparam int PHRASE_W = 64;
  localparam logic [15:0] ONCE_MAX_IDX = 16'h0007;
  localparam logic [63:0] PHRASE_ERASED = 64'hffff_ffff_ffff_ffff;

  // Block select values of global address [17:16]
  localparam logic [1:0] PF_BLK_SEL_DEF = 2'h3;
  localparam logic [1:0] DF_BLK_SEL_DEF = 2'h0;

  // Mode enable vector bit positions
  localparam int MODE_BIT_ONCE = 0;
  localparam int MODE_BIT_ALL = 1;
  localparam int MODE_BIT_BLK = 2;
  localparam int MODE_BIT_SECT = 3;
  localparam int MODE_BIT_UNSEC = 4;
  localparam int NUM_CMDS = 5;

  // Timing
  localparam int CLK_FREQ_HZ = 20_000_000;
  localparam int PROG_TIME_US = 20;
  localparam int PROG_CYC = (PROG_TIME_US * CLK_FREQ_HZ + 999_999) / 1_000_000;
  localparam int PROG_CNT_W = 12;

  localparam logic SECURE_RST = 1'b1;

  typedef enum logic [1:0] {
    FPO_ARR_ERASE_ALL = 2'b00,
    FPO_ARR_ERASE_BLK = 2'b01,
    FPO_ARR_ERASE_SECT = 2'b10
  } fpo_arr_op_t;

  typedef enum logic [2:0] {
    FPO_IDLE = 3'b000,
    FPO_EVAL = 3'b001,
    FPO_CHECK = 3'b010,
    FPO_PROG = 3'b011,
    FPO_VERIFY = 3'b100,
    FPO_ARR_WAIT = 3'b101,
    FPO_FIN = 3'b110
  } fpo_state_t;

endpackage : fpo_pkg

// ==== core/fpo_once_store.sv ====
`timescale 1ns/1ps

// Non-erasable one-time field. The cells are not touched by system reset;
// only the factory fill pulse returns them to the erased state.
module fpo_once_store
  import fpo_pkg::*;
#(
  parameter int PHRASES = ONCE_PHRASES
) (
  input wire logic clk_sys,
  input wire logic factory_fill,
  input wire logic [2:0] rd_idx,
  output logic [PHRASE_W-1:0] rd_data,
  input wire logic wr_en,
  input wire logic [2:0] wr_idx,
  input wire logic [PHRASE_W-1:0] wr_data
);

  logic [PHRASE_W-1:0] mem [PHRASES];

  // Programming can only pull bits low, so an overwrite ANDs with the old cells
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < PHRASES; i++) begin
      if (factory_fill) begin
        mem[i] <= PHRASE_ERASED;
      end else if (wr_en && (wr_idx == 3'(i))) begin
        mem[i] <= mem[i] & wr_data;
      end
    end
  end

  assign rd_data = mem[rd_idx];

endmodule : fpo_once_store

// ==== testbench/fpo_sequencer_properties.sv ====
`timescale 1ns/1ps
module fpo_sequencer_chk (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic param_wr,
  input wire logic [2:0] param_slot_index,
  input wire logic [15:0] param_rdata,
  input wire logic cmd_launch,
  input wire logic [4:0] mode_cmd_en,
  input wire logic arr_start,
  input wire logic arr_done,
  input wire logic arr_verify_err,
  input wire logic arr_verify_uncorr,
  input wire logic pflash_rd_invalid,
  input wire logic device_secured,
  input wire logic cmd_complete_flag,
  input wire logic access_error_flag,
  input wire logic protect_violation_flag,
  input wire logic verify_error_flag,
  input wire logic verify_uncorrectable_flag
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic busy_reg;
  // An array job is owed one done pulse; the flag must not return before it
  always_ff @(posedge clk_sys) begin
    if (!nrst) busy_reg <= 1'b0;
    else if (arr_start) busy_reg <= 1'b1;
    else if (arr_done) busy_reg <= 1'b0;
  end
  sequence s_launch;
    cmd_launch && cmd_complete_flag;
  endsequence
  sequence s_err_fin;
    (access_error_flag && !arr_start && !cmd_complete_flag) ##1 cmd_complete_flag;
  endsequence
  property p_launch;
    s_launch |=> !cmd_complete_flag && !access_error_flag && !protect_violation_flag && !verify_error_flag;
  endproperty
  a_launch: assert property (p_launch) else $error("launch did not clear flags");
  property p_bad_idx;
    s_launch and !(param_slot_index inside {3'h0, 3'h1, 3'h5}) |=> !arr_start ##1 s_err_fin;
  endproperty
  a_bad_idx: assert property (p_bad_idx) else $error("bad index not refused");
  property p_mode;
    s_launch and (mode_cmd_en == 5'h00) |=> !arr_start ##1 s_err_fin;
  endproperty
  a_mode: assert property (p_mode) else $error("disabled command not refused");
  property p_start;
    arr_start |-> $past(cmd_launch, 2) && !cmd_complete_flag;
  endproperty
  a_start: assert property (p_start) else $error("array start out of place");
  property p_busy;
    busy_reg |-> !cmd_complete_flag;
  endproperty
  a_busy: assert property (p_busy) else $error("flag set during array job");
  property p_done;
    arr_done && busy_reg |=> (verify_error_flag == $past(arr_verify_err)) &&
      (verify_uncorrectable_flag == $past(arr_verify_uncorr)) && !cmd_complete_flag ##1 cmd_complete_flag;
  endproperty
  a_done: assert property (p_done) else $error("verify result not reported");
  property p_secure;
    $fell(device_secured) |-> !verify_error_flag && !verify_uncorrectable_flag && !protect_violation_flag;
  endproperty
  a_secure: assert property (p_secure) else $error("security released after failure");
  property p_rd_inv;
    pflash_rd_invalid |-> !cmd_complete_flag;
  endproperty
  a_rd_inv: assert property (p_rd_inv) else $error("read invalid while idle");
  property p_hold;
    (param_wr && !cmd_complete_flag) ##1 $stable(param_slot_index) |-> $stable(param_rdata);
  endproperty
  a_hold: assert property (p_hold) else $error("slot written while busy");
endmodule : fpo_sequencer_chk

bind fpo_sequencer fpo_sequencer_chk u_chk (.clk_sys, .nrst, .param_wr, .param_slot_index, .param_rdata,
  .cmd_launch, .mode_cmd_en, .arr_start, .arr_done, .arr_verify_err, .arr_verify_uncorr, .pflash_rd_invalid,
  .device_secured, .cmd_complete_flag, .access_error_flag, .protect_violation_flag, .verify_error_flag,
  .verify_uncorrectable_flag);

// ==== testbench/test_fpo_sequencer.sv ====
`timescale 1ns/1ps
module test_fpo_sequencer;
  import fpo_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic param_wr = 1'b0;
  logic [2:0] param_slot_index = 3'h0;
  logic [15:0] param_wdata = 16'h0;
  logic cmd_launch = 1'b0;
  logic [4:0] mode_cmd_en = 5'h1f;
  logic pflash_protected_any = 1'b0;
  logic dflash_protected_any = 1'b0;
  logic sector_protected = 1'b0;
  logic arr_done = 1'b0;
  logic arr_verify_err = 1'b0;
  logic arr_verify_uncorr = 1'b0;
  logic info_factory_fill = 1'b0;
  logic [15:0] param_rdata, prot_query_addr, arr_addr;
  logic [1:0] arr_op, arr_blk, prot_query_blk;
  logic arr_start, pflash_rd_invalid, device_secured, cmd_complete_flag;
  logic access_error_flag, protect_violation_flag, verify_error_flag, verify_uncorrectable_flag;
  logic [19:0] seen;
  logic inv;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  int dly = 0;

  fpo_sequencer #(.PROG_CYCLES(4)) uut (.clk_sys, .nrst, .param_wr, .param_slot_index, .param_wdata,
    .param_rdata, .cmd_launch, .mode_cmd_en, .pflash_protected_any, .dflash_protected_any,
    .sector_protected, .prot_query_blk, .prot_query_addr, .arr_start, .arr_op, .arr_blk, .arr_addr,
    .arr_done, .arr_verify_err, .arr_verify_uncorr, .info_factory_fill, .pflash_rd_invalid,
    .device_secured, .cmd_complete_flag, .access_error_flag, .protect_violation_flag,
    .verify_error_flag, .verify_uncorrectable_flag);

  always #25 clk_sys = ~clk_sys;

  // Array stands in for the erase hardware: done a few cycles after each start
  always @(posedge clk_sys) begin
    arr_done <= (dly == 1);
    if (arr_start === 1'b1) dly <= 4;
    else if (dly > 0) dly <= dly - 1;
  end

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      n_fail++;
      wrap_up;
    end
  end

  task automatic wrap_up;
    if (n_fail == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic rst;
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
  endtask : rst

  task automatic wr(input logic [2:0] i, input logic [15:0] d);
    @(posedge clk_sys);
    param_wr <= 1'b1;
    param_slot_index <= i;
    param_wdata <= d;
    @(posedge clk_sys);
    param_wr <= 1'b0;
  endtask : wr

  // Launch, poke a slot while busy (must be ignored), then wait for completion
  task automatic go(input logic [2:0] idx, input logic [3:0] ef, input int na);
    int ns;
    ns = 0;
    inv = 1'b0;
    @(posedge clk_sys);
    param_slot_index <= idx;
    cmd_launch <= 1'b1;
    @(posedge clk_sys);
    cmd_launch <= 1'b0;
    #1 chk(cmd_complete_flag, 1'b0);
    for (int k = 0; k < 500 && cmd_complete_flag !== 1'b1; k++) begin
      @(posedge clk_sys);
      param_wr <= (k == 0);
      param_wdata <= 16'hdead;
      #1;
      if (arr_start === 1'b1) begin
        ns++;
        seen = {arr_op, arr_blk, arr_addr};
      end
      inv = inv | pflash_rd_invalid;
    end
    chk({access_error_flag, protect_violation_flag, verify_error_flag, verify_uncorrectable_flag}, ef);
    chk(ns, na);
  endtask : go

  task automatic ac(input logic [15:0] s0, input logic [15:0] s1, input logic [2:0] pr,
                    input logic [3:0] ef, input int na);
    wr(0, s0);
    wr(1, s1);
    @(posedge clk_sys);
    {pflash_protected_any, dflash_protected_any, sector_protected} <= pr;
    go(IDX_ADDR, ef, na);
  endtask : ac

  task automatic t_once;
    @(posedge clk_sys);
    info_factory_fill <= 1'b1;
    @(posedge clk_sys);
    info_factory_fill <= 1'b0;
    wr(0, {CMD_PROG_ONCE, 8'h00});
    wr(1, 16'h0003);
    for (int i = 0; i < WORDS_PER_PHRASE; i++) wr(3'(SLOT_WORD0 + i), 16'(16'h1111 * (i + 1)));
    wr(6, 16'h5555);
    #1 chk(param_rdata, 16'h0000);
    go(IDX_PROG_ONCE, 4'h0, 0);
    chk(inv, 1'b1);
    chk(param_rdata, 16'h4444);
    go(IDX_PROG_ONCE, 4'h8, 0);
    wr(1, 16'h0004);
    for (int i = 0; i < WORDS_PER_PHRASE; i++) wr(3'(SLOT_WORD0 + i), 16'hffff);
    go(IDX_PROG_ONCE, 4'h0, 0);
    go(IDX_PROG_ONCE, 4'h0, 0);
    wr(1, 16'h0008);
    go(IDX_PROG_ONCE, 4'h8, 0);
    wr(1, 16'h0007);
    go(3'h4, 4'h8, 0);
    go(IDX_PROG_ONCE, 4'h0, 0);
    @(posedge clk_sys);
    mode_cmd_en <= 5'h00;
    go(IDX_PROG_ONCE, 4'h8, 0);
    @(posedge clk_sys);
    mode_cmd_en <= 5'h1f;
  endtask : t_once

  task automatic t_all(input logic [7:0] code);
    wr(0, {code, 8'h00});
    @(posedge clk_sys);
    dflash_protected_any <= 1'b1;
    go(IDX_NO_PARAM, 4'h4, 0);
    @(posedge clk_sys);
    dflash_protected_any <= 1'b0;
    arr_verify_uncorr <= 1'b1;
    go(IDX_NO_PARAM, 4'h1, 1);
    @(posedge clk_sys);
    arr_verify_uncorr <= 1'b0;
    arr_verify_err <= 1'b1;
    go(IDX_NO_PARAM, 4'h2, 1);
    chk(device_secured, 1'b1);
    @(posedge clk_sys);
    arr_verify_err <= 1'b0;
    go(IDX_ADDR, 4'h8, 0);
    go(IDX_NO_PARAM, 4'h0, 1);
    chk({seen[19:18], device_secured}, {FPO_ARR_ERASE_ALL, 1'b0});
  endtask : t_all

  initial begin
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    #1 chk({cmd_complete_flag, device_secured, access_error_flag, pflash_rd_invalid}, 4'hc);
    t_once;
    t_all(CMD_ERASE_ALL);
    rst;
    t_all(CMD_UNSECURE);
    ac({CMD_ERASE_BLK, 8'h01}, 16'h0000, 3'h0, 4'h8, 0);
    ac({CMD_ERASE_BLK, 8'h03}, 16'h0004, 3'h0, 4'h8, 0);
    ac({CMD_ERASE_BLK, 8'h03}, 16'h0008, 3'h4, 4'h4, 0);
    ac({CMD_ERASE_BLK, 8'h03}, 16'h0008, 3'h0, 4'h0, 1);
    chk(seen, {FPO_ARR_ERASE_BLK, 2'h3, 16'h0008});
    ac({CMD_ERASE_BLK, 8'h00}, 16'h0001, 3'h0, 4'h8, 0);
    ac({CMD_ERASE_BLK, 8'h00}, 16'h0002, 3'h2, 4'h4, 0);
    ac({CMD_ERASE_BLK, 8'h00}, 16'h0002, 3'h0, 4'h0, 1);
    chk(seen, {FPO_ARR_ERASE_BLK, 2'h0, 16'h0002});
    ac({CMD_ERASE_SECT, 8'h03}, 16'h1235, 3'h0, 4'h8, 0);
    ac({CMD_ERASE_SECT, 8'h03}, 16'h1238, 3'h1, 4'h4, 0);
    ac({CMD_ERASE_SECT, 8'h03}, 16'h1238, 3'h0, 4'h0, 1);
    chk(seen, {FPO_ARR_ERASE_SECT, 2'h3, 16'h1238});
    chk(prot_query_addr, 16'h1238);
    chk(prot_query_blk, 2'h3);
    ac({CMD_ERASE_SECT, 8'h00}, 16'h1238, 3'h0, 4'h8, 0);
    ac({8'h0c, 8'h03}, 16'h0008, 3'h0, 4'h8, 0);
    wrap_up;
  end
endmodule : test_fpo_sequencer
